// [cbd_pkg.sv]
// cbd_pkg: constants and types of the configuration byte decoder
package cbd_pkg;
    // program memory locations of the two configuration bytes
    localparam logic [15:0] CFG_ADDR_LO = 16'h2018;
    localparam logic [15:0] CFG_ADDR_HI = 16'h201a;
    // low configuration byte fields
    localparam int LO_PWR_ALLOW = 0;
    localparam int LO_WIDTH_LO = 1;
    localparam int LO_WRS = 2;
    localparam int LO_ALE = 3;
    localparam int LO_WAIT_B0 = 4;
    localparam int LO_WAIT_B1 = 5;
    localparam int LO_PROT_LO = 6;
    localparam int LO_PROT_HI = 7;
    // high configuration byte fields
    localparam int HI_RSV0 = 0;
    localparam int HI_WAIT_B2 = 1;
    localparam int HI_WIDTH_HI = 2;
    localparam int HI_WDT_FORCE = 3;
    localparam int HI_RSV4 = 4;
    localparam int HI_RSV5 = 5;
    localparam int HI_MS0 = 6;
    localparam int HI_MS1 = 7;
    localparam logic HI_RSV0_VAL = 1'b0;
    localparam logic [1:0] HI_RSV54_VAL = 2'b01;
    // register byte offsets
    localparam logic [7:0] REG_CFG_LO = 8'h00;
    localparam logic [7:0] REG_CFG_HI = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam int CTRL_WDT_EN = 0;
    localparam int CTRL_PWR_REQ = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int STAT_DONE = 0;
    localparam int STAT_UNSUP = 1;
    localparam int STAT_WBAD = 2;
    localparam int STAT_WDT = 3;
    localparam int STAT_PWR = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // bus timing in core clock ticks; one tick is half an oscillator period
    localparam logic [5:0] OSC_TICKS = 6'h02;
    localparam logic [5:0] STATE_TICKS = 6'h04;
    localparam logic [5:0] HALF_OSC = 6'h01;
    localparam logic [2:0] MAX_WAITS = 3'h4;
    typedef enum logic [1:0] {
        MODE0 = 2'h0,
        MODE1 = 2'h1,
        MODE2 = 2'h2,
        MODE3 = 2'h3
    } cbd_tmode_e;
    typedef enum logic [3:0] {
        ST_FLO = 4'h1,
        ST_FHI = 4'h2,
        ST_IDLE = 4'h4,
        ST_CYC = 4'h8
    } cbd_state_e;
    typedef struct packed {
        logic pwr_allow;
        logic wr_single;
        logic ale_mode;
        logic [2:0] wait_lim;
        logic [1:0] prot;
        logic [1:0] width;
        cbd_tmode_e tmode;
        logic wdt_force;
        logic unsup;
    } cbd_cfg_s;
endpackage : cbd_pkg

// [cbd_top.sv]
// cbd_top: configuration byte fetch, decode and external bus cycle engine
// Notes on behaviour
// R1: fetch both bytes after reset, then run
// R2: select single write strobe or split strobes
// R3: strobe pin is latch pulse or valid
// R4: wait field caps inserted wait states
// R5: low ready extends cycle up to cap
// R6: protection field blocks reads and/or writes
// R7: width field forces 8, 16 or pin
// R8: far side drives width pin per cycle
// R9: mode 0 always adds one wait state
// R10: mode 1 advances strobes, pulse stays
// R11: mode 2 also advances the address
// R12: watchdog forced on when bit clear
// R13: powerdown request needs allow bit set
// R14: reserved bits hold their fixed values
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module cbd_top
    import cbd_pkg::*;
#(
    parameter int ADDR_W = 16
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // axi4-lite register slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // configuration byte fetch from program memory
    output logic cfg_rd_req,
    output logic [ADDR_W-1:0] cfg_rd_addr,
    input wire logic cfg_rd_ack,
    input wire logic [7:0] cfg_rd_data,
    output logic cpu_run,
    // core request port
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_be,
    input wire logic [15:0] req_wdata,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    // external multiplexed bus
    output logic [15:0] ad_o,
    output logic ad_oe,
    input wire logic [15:0] ad_i,
    output logic addr_strobe_pin,
    output logic rd_n,
    output logic wr_lo_pin_n,
    output logic hi_pin_n,
    input wire logic ready_i,
    input wire logic width_pin_i,
    // system controls
    output logic wdt_enable,
    output logic powerdown_go,
    output logic prot_read_block,
    output logic prot_write_block
);
    initial
    begin
        if (ADDR_W != 16)
            $error("cbd_top: ADDR_W must be 16");
    end

    cbd_state_e st_r;
    logic [7:0] cfg_lo_r, cfg_hi_r;
    cbd_cfg_s cfg;
    logic [1:0] ctrl_r;
    logic [5:0] tk_r, str_end_r;
    logic [2:0] wcnt_r, lim_eff;
    logic wide_r, wr_r, split_r, hi_pass_r, dec_tick;
    logic [1:0] be_r;
    logic [15:0] addr_r, wdata_r;
    logic [5:0] a_start, ale_start, str_start;
    logic ale_win, str_win, adr_win, last_tick;

    // field decode of the fetched bytes
    always_comb
    begin
        cfg.pwr_allow = cfg_lo_r[LO_PWR_ALLOW];
        cfg.wr_single = cfg_lo_r[LO_WRS];
        cfg.ale_mode = cfg_lo_r[LO_ALE];
        cfg.wait_lim = {cfg_hi_r[HI_WAIT_B2], cfg_lo_r[LO_WAIT_B1], cfg_lo_r[LO_WAIT_B0]};
        cfg.prot = {cfg_lo_r[LO_PROT_HI], cfg_lo_r[LO_PROT_LO]};
        cfg.width = {cfg_hi_r[HI_WIDTH_HI], cfg_lo_r[LO_WIDTH_LO]};
        cfg.tmode = cbd_tmode_e'({cfg_hi_r[HI_MS1], cfg_hi_r[HI_MS0]});
        cfg.wdt_force = cfg_hi_r[HI_WDT_FORCE];
        // R14 reserved values
        cfg.unsup = (cfg_hi_r[HI_RSV0] != HI_RSV0_VAL)
            || ({cfg_hi_r[HI_RSV5], cfg_hi_r[HI_RSV4]} != HI_RSV54_VAL)
            || (cfg.width == 2'b00);
    end

    // R4 wait cap; R9 mode 0 auto wait on top
    always_comb
    begin
        unique case (cfg.wait_lim)
            3'b000: lim_eff = 3'h0;
            3'b100: lim_eff = 3'h1;
            3'b101: lim_eff = 3'h2;
            3'b110, 3'b111: lim_eff = 3'h3;
            default: lim_eff = 3'h0;
        endcase
        if (cfg.tmode == MODE0)
            lim_eff = lim_eff + 3'h1;
    end

    // R10 R11 per-mode placement of address and strobes
    always_comb
    begin
        a_start = (cfg.tmode == MODE2) ? 6'h00 : HALF_OSC;
        ale_start = (cfg.tmode == MODE1 || cfg.tmode == MODE2) ? 6'h00 : HALF_OSC;
        str_start = (cfg.tmode == MODE1 || cfg.tmode == MODE2)
            ? STATE_TICKS - OSC_TICKS : STATE_TICKS;
    end

    assign dec_tick = (st_r == ST_CYC) && (tk_r == str_end_r - 6'h01);
    assign last_tick = (st_r == ST_CYC) && (tk_r == str_end_r);
    assign ale_win = (st_r == ST_CYC) && (tk_r >= ale_start)
        && (tk_r < ale_start + OSC_TICKS);
    assign adr_win = (st_r == ST_CYC) && (tk_r >= a_start) && (tk_r < str_start);
    assign str_win = (st_r == ST_CYC) && (tk_r >= str_start) && (tk_r < str_end_r);

    // R1 fetch sequence and cycle control
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= ST_FLO;
            cfg_lo_r <= 8'h00;
            cfg_hi_r <= 8'h00;
        end
        else
        begin
            unique case (st_r)
                ST_FLO:
                    if (cfg_rd_ack)
                    begin
                        cfg_lo_r <= cfg_rd_data;
                        st_r <= ST_FHI;
                    end
                ST_FHI:
                    if (cfg_rd_ack)
                    begin
                        cfg_hi_r <= cfg_rd_data;
                        st_r <= ST_IDLE;
                    end
                ST_IDLE:
                    if (req_valid)
                        st_r <= ST_CYC;
                ST_CYC:
                    if (last_tick && !split_r)
                        st_r <= ST_IDLE;
            endcase
        end
    end

    assign cfg_rd_req = (st_r == ST_FLO) || (st_r == ST_FHI);
    assign cfg_rd_addr = (st_r == ST_FHI) ? CFG_ADDR_HI : CFG_ADDR_LO;
    assign cpu_run = !cfg_rd_req;
    assign req_ready = (st_r == ST_IDLE);

    // bus cycle tick counter, wait states and byte passes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tk_r <= 6'h00;
            str_end_r <= 6'h00;
            wcnt_r <= 3'h0;
            wide_r <= 1'b0;
            wr_r <= 1'b0;
            be_r <= 2'h0;
            split_r <= 1'b0;
            hi_pass_r <= 1'b0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
        end
        else if (st_r == ST_IDLE && req_valid)
        begin
            tk_r <= 6'h00;
            str_end_r <= str_start + STATE_TICKS;
            wcnt_r <= 3'h0;
            wr_r <= req_write;
            be_r <= req_be;
            addr_r <= req_addr;
            wdata_r <= req_wdata;
            // R7 width from field or pin; R8 pin held by far side
            wide_r <= cfg.width[1] && (!cfg.width[0] || width_pin_i);
            split_r <= !(cfg.width[1] && (!cfg.width[0] || width_pin_i))
                && (req_be == 2'b11);
            hi_pass_r <= !(cfg.width[1] && (!cfg.width[0] || width_pin_i))
                && (req_be == 2'b10);
        end
        else if (st_r == ST_CYC)
        begin
            tk_r <= tk_r + 6'h01;
            // R9 R5 first wait automatic in mode 0, rest on low ready
            if (dec_tick && wcnt_r < lim_eff
                && ((cfg.tmode == MODE0 && wcnt_r == 3'h0) || !ready_i))
            begin
                str_end_r <= str_end_r + STATE_TICKS;
                wcnt_r <= wcnt_r + 3'h1;
            end
            if (last_tick && split_r)
            begin
                split_r <= 1'b0;
                hi_pass_r <= 1'b1;
                tk_r <= 6'h00;
                str_end_r <= str_start + STATE_TICKS;
                wcnt_r <= 3'h0;
            end
        end
    end

    // read data capture, one byte lane per narrow pass
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rsp_rdata <= 16'h0000;
            rsp_valid <= 1'b0;
        end
        else
        begin
            rsp_valid <= last_tick && !split_r;
            if (last_tick && !wr_r)
            begin
                if (wide_r)
                    rsp_rdata <= ad_i;
                else if (hi_pass_r)
                    rsp_rdata[15:8] <= ad_i[7:0];
                else
                    rsp_rdata[7:0] <= ad_i[7:0];
            end
        end
    end

    // pins; narrow passes carry the odd byte on the low lane
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ad_o <= 16'h0000;
            ad_oe <= 1'b0;
            addr_strobe_pin <= 1'b0;
            rd_n <= 1'b1;
            wr_lo_pin_n <= 1'b1;
            hi_pin_n <= 1'b1;
        end
        else
        begin
            ad_oe <= adr_win || (str_win && wr_r);
            if (adr_win)
                ad_o <= hi_pass_r ? (addr_r | 16'h0001) : addr_r;
            else if (wide_r)
                ad_o <= wdata_r;
            else
                ad_o <= {8'h00, hi_pass_r ? wdata_r[15:8] : wdata_r[7:0]};
            // R3 latch pulse, or valid low until the cycle ends
            if (cfg.ale_mode)
                addr_strobe_pin <= ale_win;
            else
                addr_strobe_pin <= !((st_r == ST_CYC) && tk_r >= ale_start
                    && !last_tick);
            rd_n <= !(str_win && !wr_r);
            // R2 single strobe plus byte enable, or split strobes
            if (cfg.wr_single)
            begin
                wr_lo_pin_n <= !(str_win && wr_r);
                hi_pin_n <= !((st_r == ST_CYC) && !last_tick
                    && (wide_r ? be_r[1] : hi_pass_r));
            end
            else
            begin
                wr_lo_pin_n <= !(str_win && wr_r && (wide_r ? be_r[0] : !hi_pass_r));
                hi_pin_n <= !(str_win && wr_r && (wide_r ? be_r[1] : hi_pass_r));
            end
        end
    end

    // axi4-lite slave; write taken only with address and data both present
    logic aw_hit, ar_ok;
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign aw_hit = s_axi_awaddr == REG_CTRL;
    assign ar_ok = s_axi_araddr == REG_CFG_LO || s_axi_araddr == REG_CFG_HI
        || s_axi_araddr == REG_CTRL || s_axi_araddr == REG_STAT;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl_r <= CTRL_RST;
        end
        else
        begin
            if (s_axi_awready)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_hit ? RESP_OKAY : RESP_SLVERR;
                if (aw_hit && s_axi_wstrb[0])
                    ctrl_r <= s_axi_wdata[1:0];
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ar_ok ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= 32'h0000_0000;
            unique case (s_axi_araddr)
                REG_CFG_LO: s_axi_rdata[7:0] <= cfg_lo_r;
                REG_CFG_HI: s_axi_rdata[7:0] <= cfg_hi_r;
                REG_CTRL: s_axi_rdata[1:0] <= ctrl_r;
                REG_STAT: s_axi_rdata[4:0] <= {powerdown_go, wdt_enable,
                    cfg.width == 2'b00, cfg.unsup, cpu_run};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // R12 watchdog cannot be switched off when the bit is clear
    assign wdt_enable = cpu_run && (!cfg.wdt_force || ctrl_r[CTRL_WDT_EN]);
    // R13 powerdown only when allowed
    assign powerdown_go = cpu_run && cfg.pwr_allow && ctrl_r[CTRL_PWR_REQ];
    // R6 protection codes, protected until the bytes are in
    assign prot_read_block = !cpu_run || cfg.prot == 2'b00 || cfg.prot == 2'b01;
    assign prot_write_block = !cpu_run || cfg.prot == 2'b00 || cfg.prot == 2'b10;

    property p_fetch_lo;
        @(posedge core_clk) disable iff (!arst_n)
        st_r == ST_FLO |-> cfg_rd_req && cfg_rd_addr == CFG_ADDR_LO && !req_ready;
    endproperty
    a_fetch_lo: assert property (p_fetch_lo) else $error("fetch order wrong"); // R1
    property p_single_wr;
        @(posedge core_clk) disable iff (!arst_n)
        cfg.wr_single && str_win && wr_r |=> !wr_lo_pin_n;
    endproperty
    a_single_wr: assert property (p_single_wr) else $error("write strobe missing"); // R2
    property p_adv_end;
        @(posedge core_clk) disable iff (!arst_n)
        !cfg.ale_mode && last_tick |=> addr_strobe_pin;
    endproperty
    a_adv_end: assert property (p_adv_end) else $error("valid not released"); // R3
    property p_wait_cap;
        @(posedge core_clk) disable iff (!arst_n)
        st_r == ST_CYC |-> wcnt_r <= lim_eff && wcnt_r <= MAX_WAITS;
    endproperty
    a_wait_cap: assert property (p_wait_cap) else $error("too many waits"); // R4
    property p_ready_go;
        @(posedge core_clk) disable iff (!arst_n)
        dec_tick && ready_i && !(cfg.tmode == MODE0 && wcnt_r == 3'h0) |=> last_tick;
    endproperty
    a_ready_go: assert property (p_ready_go) else $error("cycle not ended"); // R5
    property p_prot_all;
        @(posedge core_clk) disable iff (!arst_n)
        cfg.prot == 2'b00 |-> prot_read_block && prot_write_block;
    endproperty
    a_prot_all: assert property (p_prot_all) else $error("protection off"); // R6
    property p_width8;
        @(posedge core_clk) disable iff (!arst_n)
        st_r == ST_IDLE && req_valid && cfg.width == 2'b01 |=> !wide_r;
    endproperty
    a_width8: assert property (p_width8) else $error("wide cycle in 8-bit"); // R7
    property p_mode0_wait;
        @(posedge core_clk) disable iff (!arst_n)
        cfg.tmode == MODE0 && last_tick |-> wcnt_r >= 3'h1;
    endproperty
    a_mode0_wait: assert property (p_mode0_wait) else $error("no auto wait"); // R9
    property p_ale_width;
        @(posedge core_clk) disable iff (!arst_n)
        cfg.ale_mode && $rose(addr_strobe_pin) |=> addr_strobe_pin ##1 !addr_strobe_pin;
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("pulse width wrong"); // R10
    property p_wdt_pd;
        @(posedge core_clk) disable iff (!arst_n)
        cpu_run |-> (cfg.wdt_force || wdt_enable) && (cfg.pwr_allow || !powerdown_go);
    endproperty
    a_wdt_pd: assert property (p_wdt_pd) else $error("watchdog or powerdown"); // R12
endmodule : cbd_top
`default_nettype wire

// [cbd_far.sv]
// cbd_far: far-side model of the config memory and the external bus memory
`timescale 1ns/1ps
`default_nettype none
module cbd_far
    import cbd_pkg::*;
#(
    parameter logic [15:0] RD_PAT = 16'ha5c3
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // config byte memory
    input wire logic cfg_rd_req,
    input wire logic [15:0] cfg_rd_addr,
    output logic cfg_rd_ack,
    output logic [7:0] cfg_rd_data,
    input wire logic [7:0] cfg_lo,
    input wire logic [7:0] cfg_hi,
    // external bus
    input wire logic rd_n,
    output logic [15:0] ad_i,
    output logic ready_i,
    output logic width_pin_i,
    input wire logic slow,
    input wire logic wide
);
    logic [1:0] cnt_r;
    logic rd_q_r;
    logic [7:0] sel;
    assign sel = (cfg_rd_addr == CFG_ADDR_LO) ? cfg_lo :
                 (cfg_rd_addr == CFG_ADDR_HI) ? cfg_hi : 8'h00;
    // answer slowly so the fetch window is visible
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 2'h0;
            cfg_rd_ack <= 1'b0;
            rd_q_r <= 1'b1;
        end
        else
        begin
            cnt_r <= cfg_rd_ack ? 2'h0 : cnt_r + {1'b0, cfg_rd_req};
            cfg_rd_ack <= cfg_rd_req && !cfg_rd_ack && cnt_r == 2'h3;
            rd_q_r <= rd_n;
        end
    end
    // released lines show the inverse, never a stale value
    assign cfg_rd_data = cfg_rd_ack ? sel : ~sel;
    assign ad_i = (!rd_n || !rd_q_r) ? RD_PAT : ~RD_PAT;
    assign ready_i = !slow;
    assign width_pin_i = wide;
endmodule : cbd_far
`default_nettype wire

// [cbd_top_test.sv]
// cbd_top_test: register, decode and bus cycle checks of the config decoder
`timescale 1ns/1ps
`default_nettype none
module cbd_top_test
    import cbd_pkg::*;
;
    logic core_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cfg_lo, cfg_hi, cfg_rd_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, req_be;
    logic cfg_rd_req, cfg_rd_ack, cpu_run, req_valid, req_ready, req_write, rsp_valid;
    logic [15:0] cfg_rd_addr, req_addr, req_wdata, rsp_rdata, ad_o, ad_i;
    logic ad_oe, addr_strobe_pin, rd_n, wr_lo_pin_n, hi_pin_n, ready_i, width_pin_i;
    logic wdt_enable, powerdown_go, prot_read_block, prot_write_block, slow, wide;
    logic rd_q, wrl, hil, ash, asl;
    logic [15:0] adr;
    int mismatches, comparisons, rdf, base, lat, aon;
    cbd_top DUT (.core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_rd_req,
        .cfg_rd_addr, .cfg_rd_ack, .cfg_rd_data, .cpu_run, .req_valid, .req_ready,
        .req_write, .req_addr, .req_be, .req_wdata, .rsp_valid, .rsp_rdata, .ad_o, .ad_oe,
        .ad_i, .addr_strobe_pin, .rd_n, .wr_lo_pin_n, .hi_pin_n, .ready_i, .width_pin_i,
        .wdt_enable, .powerdown_go, .prot_read_block, .prot_write_block);
    cbd_far far (.core_clk, .arst_n, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_ack, .cfg_rd_data,
        .cfg_lo, .cfg_hi, .rd_n, .ad_i, .ready_i, .width_pin_i, .slow, .wide);
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // strobe edges and levels seen during one bus operation
    always @(posedge core_clk)
    begin
        if (rd_n === 1'b0 && rd_q === 1'b1) rdf++;
        rd_q <= rd_n;
        if (wr_lo_pin_n === 1'b0) wrl = 1'b1;
        if (hi_pin_n === 1'b0) hil = 1'b1;
        if (addr_strobe_pin === 1'b1) ash = 1'b1;
        if (addr_strobe_pin === 1'b0) asl = 1'b1;
        // address drive: first value put out and number of driven cycles
        if (ad_oe === 1'b1)
        begin
            if (aon == 0)
                adr = ad_o;
            aon++;
        end
    end
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    // every wait is bounded; running out ends the run
    task step(inout int n);
        @(posedge core_clk);
        n++;
        if (n > 500)
        begin
            mismatches++;
            $display("MISMATCH wait expected done seen timeout");
            complete_run();
        end
    endtask : step
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do step(n); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do step(n); while (s_axi_bvalid !== 1'b1);
        check("bresp", s_axi_bresp, er);
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do step(n); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do step(n); while (s_axi_rvalid !== 1'b1);
        check("rdata", s_axi_rdata, ed);
        check("rresp", s_axi_rresp, er);
    endtask : axi_rd
    task bus(input logic w, input logic [1:0] be);
        int n;
        n = 0;
        rdf = 0;
        {wrl, hil, ash, asl} = 4'h0;
        aon = 0;
        adr = 16'h0000;
        req_write <= w;
        req_be <= be;
        req_valid <= 1'b1;
        do step(n); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        lat = 0;
        do step(lat); while (rsp_valid !== 1'b1);
        step(n);
        step(n);
    endtask : bus
    task cfg_test(input logic [7:0] lo, input logic [7:0] hi, input logic [4:0] st,
        input logic [1:0] pb);
        int n;
        n = 0;
        cfg_lo <= lo;
        cfg_hi <= hi;
        arst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        check("cpu_run", cpu_run, 32'h0);
        check("req_ready", req_ready, 32'h0);
        do step(n); while (cpu_run !== 1'b1);
        axi_rd(REG_CFG_LO, {24'h0, lo}, RESP_OKAY);
        axi_rd(REG_CFG_HI, {24'h0, hi}, RESP_OKAY);
        axi_rd(REG_STAT, {27'h0, st}, RESP_OKAY);
        axi_rd(REG_CTRL, {30'h0, CTRL_RST}, RESP_OKAY);
        check("prot", {prot_read_block, prot_write_block}, pb);
        check("wdt", wdt_enable, st[STAT_WDT]);
        axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
        check("powerdown", powerdown_go, lo[LO_PWR_ALLOW]);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        check("wdt on", wdt_enable, 32'h1);
        axi_wr(REG_CFG_LO, 32'hff, RESP_SLVERR);
        axi_rd(REG_CFG_LO, {24'h0, lo}, RESP_OKAY);
        axi_rd(8'h10, 32'h0, RESP_SLVERR);
    endtask : cfg_test
    initial
    begin
        {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, req_valid, req_write} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, cfg_lo, cfg_hi} = 32'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        req_be = 2'h3;
        req_addr = 16'h4000;
        req_wdata = 16'h1234;
        {slow, wide, rd_q} = 3'h3;
        mismatches = 0;
        comparisons = 0;
        // reserved bits at their fixed values except in the last set
        cfg_test(8'hcf, 8'hdc, 5'h01, 2'b00);
        slow <= 1'b0;
        bus(1'b0, 2'h3);
        base = lat;
        check("rdata16", rsp_rdata, 16'ha5c3);
        check("addr", adr, req_addr);
        check("addr ticks m3", aon, 32'h3);
        check("passes16", rdf, 32'h1);
        slow <= 1'b1;
        bus(1'b0, 2'h3);
        check("cap0", lat, base);
        wide <= 1'b0;
        bus(1'b0, 2'h3);
        check("passes8", rdf, 32'h2);
        check("rdata8", rsp_rdata, 16'hc3c3);
        wide <= 1'b1;
        bus(1'b1, 2'h2);
        check("wr single", {wrl, hil}, 2'b11);
        bus(1'b1, 2'h1);
        check("wr single lo", {wrl, hil}, 2'b10);
        check("ale", {ash, addr_strobe_pin}, 2'b10);
        $display("test 1 done");
        cfg_test(8'h00, 8'h16, 5'h09, 2'b11);
        slow <= 1'b0;
        bus(1'b0, 2'h3);
        check("mode0 wait", lat, base + 4);
        check("passes16", rdf, 32'h1);
        slow <= 1'b1;
        bus(1'b0, 2'h3);
        check("mode0 cap", lat, base + 8);
        bus(1'b1, 2'h2);
        check("wr split hi", {wrl, hil}, 2'b01);
        bus(1'b1, 2'h1);
        check("wr split lo", {wrl, hil}, 2'b10);
        check("adv", {asl, addr_strobe_pin}, 2'b11);
        $display("test 2 done");
        cfg_test(8'h5f, 8'h5a, 5'h01, 2'b10);
        bus(1'b0, 2'h1);
        check("mode1", lat, base + 6);
        check("addr ticks m1", aon, 32'h1);
        bus(1'b0, 2'h3);
        check("passes8", rdf, 32'h2);
        $display("test 3 done");
        cfg_test(8'ha0, 8'h93, 5'h0f, 2'b01);
        bus(1'b0, 2'h1);
        check("mode2", lat, base + 10);
        check("addr ticks m2", aon, 32'h2);
        $display("test 4 done");
        complete_run();
    end
endmodule : cbd_top_test
`default_nettype wire
